// File: src/scil_irq_top.sv
// Notes on behaviour
// - eleven enable bits, one per source
// - enables reset to zero, upper bits reserved
// - status resets with only transmit-empty set
// - bad convention character sets sticky flag
// - time-out flag clears once buffer drained
// - one sequence-end flag, write one clears
// - sequence finish clears start, sets flag
// - card insert or removal sets sticky flag
// - guard flag set only while guard function on
// - three timer flags, write one clears
// - transfer error is OR of seven
// - transmit-empty cleared by holding port write
// - receive level flag tracks trigger level
// - time-out counter restarts on each byte
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "scil_defs.svh"

module scil_irq_top #(
  parameter int ADDR_W = 8,
  parameter int TO_W   = 9
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                clkEn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                convCharValid,
  input  wire logic [7:0]          convChar,
  input  wire logic                cardInserted,
  input  wire logic                cardRemoved,
  input  wire logic                guardTimeEvent,
  input  wire logic [2:0]          timerEvent,
  input  wire scil_pkg::scil_err_t errFlags,
  input  wire logic                txEmpty,
  input  wire logic                txHoldWrite,
  input  wire logic                rxByteIn,
  input  wire logic                rxBufRead,
  input  wire logic [2:0]          rxCount,
  input  wire logic [1:0]          rxTriggerLevel,
  input  wire logic [TO_W-1:0]     rxTimeoutValue,
  input  wire logic                etuTick,
  input  wire logic [2:0]          seqDone,
  output logic [2:0]               seqStart,
  output logic                     rxGuardOn,
  output logic                     irq
);

  localparam int FW = `SCIL_FLAG_W;

  scil_pkg::scil_wr_t wrReq;
  logic [FW-1:0]      enable_r;
  logic [FW-1:0]      flags_r;
  logic [FW-1:0]      flags_nxt;
  logic [FW-1:0]      flagSet;
  logic [FW-1:0]      flagClr;
  logic [2:0]         seqStart_r;
  logic               guardOn_r;
  logic               insPrev_r;
  logic               remPrev_r;
  logic               txePrev_r;
  logic               toPulse;
  logic [31:0]        laneMask;
  logic [31:0]        wrBits;
  logic               wrEnable;
  logic               wrStatus;
  logic               wrSeq;
  logic               wrErr;
  logic               rdErr;
  logic [31:0]        rdData;
  logic               convBad;
  logic               cardEdge;
  logic [2:0]         rxThreshold;
  logic               rxReached;

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `SCIL_OFS_ENABLE) | (a == `SCIL_OFS_STATUS) | (a == `SCIL_OFS_SEQCTL);
  endfunction : isMapped

  function automatic logic [31:0] strbToMask(input logic [3:0] s);
    strbToMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strbToMask

  // ----------------------------------------------------------------
  // bus slave and time-out counter
  // ----------------------------------------------------------------
  scil_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .mclk          (mclk),
    .rst           (rst),
    .clkEn         (clkEn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrReq         (wrReq),
    .wrErr         (wrErr),
    .rdData        (rdData),
    .rdErr         (rdErr)
  );

  scil_rx_timeout #(
    .CNT_W (TO_W)
  ) u_rxto (
    .mclk         (mclk),
    .rst          (rst),
    .clkEn        (clkEn),
    .rxByteIn     (rxByteIn),
    .rxBufRead    (rxBufRead),
    .etuTick      (etuTick),
    .timeoutValue (rxTimeoutValue),
    .timeoutPulse (toPulse)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign wrErr    = ~isMapped(wrReq.addr);
  assign rdErr    = ~isMapped(8'(s_axi_araddr));
  assign laneMask = strbToMask(wrReq.strb);
  assign wrBits   = wrReq.data & laneMask;
  assign wrEnable = wrReq.en & (wrReq.addr == `SCIL_OFS_ENABLE);
  assign wrStatus = wrReq.en & (wrReq.addr == `SCIL_OFS_STATUS);
  assign wrSeq    = wrReq.en & (wrReq.addr == `SCIL_OFS_SEQCTL);

  assign rdData = (8'(s_axi_araddr) == `SCIL_OFS_ENABLE) ? {{(32-FW){1'b0}}, enable_r} :
                  (8'(s_axi_araddr) == `SCIL_OFS_STATUS) ? {{(32-FW){1'b0}}, flags_r} :
                  (8'(s_axi_araddr) == `SCIL_OFS_SEQCTL) ? {28'h0000000, guardOn_r, seqStart_r} :
                  32'h00000000;

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  // convention character check
  assign convBad     = convCharValid & (convChar != `SCIL_TS_DIRECT) & (convChar != `SCIL_TS_INVERSE);
  assign cardEdge    = (cardInserted & ~insPrev_r) | (cardRemoved & ~remPrev_r);
  // trigger level is field plus one
  assign rxThreshold = {1'b0, rxTriggerLevel} + 3'h1;
  assign rxReached   = (rxCount >= rxThreshold);

  always_comb begin
    flagSet                                     = '0;
    flagSet[`SCIL_BIT_CONV]                     = convBad;
    flagSet[`SCIL_BIT_RXTO]                     = toPulse;
    flagSet[`SCIL_BIT_SEQ]                      = |seqDone;
    flagSet[`SCIL_BIT_CD]                       = cardEdge;
    // guard event gated by function enable
    flagSet[`SCIL_BIT_GT]                       = guardTimeEvent & guardOn_r;
    flagSet[`SCIL_BIT_TMR_HI:`SCIL_BIT_TMR_LO]  = timerEvent;
    flagSet[`SCIL_BIT_TXE]                      = txEmpty & ~txePrev_r;
  end

  // only ones in sticky positions clear
  assign flagClr = wrStatus ? (wrBits[FW-1:0] & `SCIL_W1C_MASK) : '0;

  always_comb begin
    // sticky flags, set wins over clear
    flags_nxt                = (flags_r & ~flagClr) | flagSet;
    flags_nxt[`SCIL_BIT_RXTO] = toPulse | (flags_r[`SCIL_BIT_RXTO] & (rxCount != 3'h0));
    // live OR of the error sources
    flags_nxt[`SCIL_BIT_TERR] = |errFlags;
    flags_nxt[`SCIL_BIT_TXE]  = flagSet[`SCIL_BIT_TXE] | (flags_r[`SCIL_BIT_TXE] & ~txHoldWrite);
    flags_nxt[`SCIL_BIT_RXL]  = rxReached;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable_r <= `SCIL_ENABLE_RST;
      flags_r  <= `SCIL_STATUS_RST;
    end else if (clkEn) begin
      if (wrEnable) begin
        enable_r <= (enable_r & ~laneMask[FW-1:0]) | wrBits[FW-1:0];
      end
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seqStart_r <= '0;
      guardOn_r  <= 1'b0;
      insPrev_r  <= 1'b0;
      remPrev_r  <= 1'b0;
      txePrev_r  <= 1'b1;
    end else if (clkEn) begin
      // finish clears start, new request wins
      seqStart_r <= (seqStart_r & ~seqDone) | (wrSeq ? wrBits[`SCIL_SEQ_START_HI:0] : 3'h0);
      if (wrSeq & laneMask[`SCIL_SEQ_GUARD]) begin
        guardOn_r <= wrReq.data[`SCIL_SEQ_GUARD];
      end
      insPrev_r <= cardInserted;
      remPrev_r <= cardRemoved;
      txePrev_r <= txEmpty;
    end
  end

  assign seqStart  = seqStart_r;
  assign rxGuardOn = guardOn_r;
  // level request from flags and enables
  assign irq       = |(flags_r & enable_r);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_seqFinish;
    clkEn && seqDone[0] && !(wrSeq && wrBits[0]);
  endsequence

  sequence s_seqReported;
    !seqStart_r[0] && flags_r[`SCIL_BIT_SEQ];
  endsequence

  property p_seq_end;
    @(posedge mclk) disable iff (rst) s_seqFinish |=> s_seqReported;
  endproperty
  a_seq_end: assert property (p_seq_end) else $error("sequence finish not reported");

  property p_conv_err;
    @(posedge mclk) disable iff (rst) (clkEn && convBad) |=> flags_r[`SCIL_BIT_CONV];
  endproperty
  a_conv_err: assert property (p_conv_err) else $error("convention error missed");

  property p_conv_ok;
    @(posedge mclk) disable iff (rst)
      (clkEn && convCharValid && convChar == `SCIL_TS_DIRECT && !flags_r[`SCIL_BIT_CONV]) |=> !flags_r[`SCIL_BIT_CONV];
  endproperty
  a_conv_ok: assert property (p_conv_ok) else $error("legal convention flagged");

  property p_card;
    @(posedge mclk) disable iff (rst)
      (clkEn && cardEdge) |=> flags_r[`SCIL_BIT_CD] ##1 (flags_r[`SCIL_BIT_CD] || $past(wrStatus));
  endproperty
  a_card: assert property (p_card) else $error("card detect flag not held");

  property p_guard_off;
    @(posedge mclk) disable iff (rst)
      (clkEn && !guardOn_r && !flags_r[`SCIL_BIT_GT]) |=> !flags_r[`SCIL_BIT_GT];
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("guard flag set while off");

  property p_terr;
    @(posedge mclk) disable iff (rst) clkEn |=> flags_r[`SCIL_BIT_TERR] == ($past(errFlags) != 7'h00);
  endproperty
  a_terr: assert property (p_terr) else $error("transfer error flag wrong");

  property p_txe_clear;
    @(posedge mclk) disable iff (rst)
      (clkEn && txHoldWrite && !(txEmpty && !txePrev_r)) |=> !flags_r[`SCIL_BIT_TXE];
  endproperty
  a_txe_clear: assert property (p_txe_clear) else $error("transmit empty not cleared");

  property p_rx_level;
    @(posedge mclk) disable iff (rst) clkEn |=> flags_r[`SCIL_BIT_RXL] == $past(rxReached);
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("receive level flag wrong");

  property p_zero_write;
    @(posedge mclk) disable iff (rst)
      (clkEn && wrStatus && wrBits == 32'h00000000) |=> ((($past(flags_r) & ~flags_r) & `SCIL_W1C_MASK) == '0);
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write cleared a flag");

  property p_irq;
    @(posedge mclk) disable iff (rst)
      (clkEn && wrEnable && wrBits[`SCIL_BIT_TMR_LO] && flags_r[`SCIL_BIT_TMR_LO]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_reset_state;
    @(posedge mclk) $fell(rst) |-> (enable_r == `SCIL_ENABLE_RST) && flags_r[`SCIL_BIT_TXE];
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset values wrong");

endmodule : scil_irq_top

// File: src/scil_defs.svh
`ifndef SCIL_DEFS_SVH
`define SCIL_DEFS_SVH

// register byte offsets
`define SCIL_OFS_ENABLE   8'h18
`define SCIL_OFS_STATUS   8'h1C
`define SCIL_OFS_SEQCTL   8'h40

// flag layout, shared by enable and status
`define SCIL_FLAG_W       11
`define SCIL_ENABLE_RST   11'h000
`define SCIL_STATUS_RST   11'h002
`define SCIL_W1C_MASK     11'h5F8
`define SCIL_BIT_CONV     10
`define SCIL_BIT_RXTO     9
`define SCIL_BIT_SEQ      8
`define SCIL_BIT_CD       7
`define SCIL_BIT_GT       6
`define SCIL_BIT_TMR_HI   5
`define SCIL_BIT_TMR_LO   3
`define SCIL_BIT_TERR     2
`define SCIL_BIT_TXE      1
`define SCIL_BIT_RXL      0

// sequence control layout
`define SCIL_SEQ_W        3
`define SCIL_SEQ_START_HI 2
`define SCIL_SEQ_GUARD    3

// legal initial convention characters
`define SCIL_TS_DIRECT    8'h3B
`define SCIL_TS_INVERSE   8'h3F

// time-out counter fires when it stands at this value
`define SCIL_TO_FIRE      9'h001

`define SCIL_RESP_OKAY    2'h0
`define SCIL_RESP_SLVERR  2'h2

`endif

// File: src/scil_pkg.sv
package scil_pkg;

  // the seven transfer error sources
  typedef struct packed {
    logic rxBreak;
    logic rxFrameError;
    logic rxParityError;
    logic rxOverflow;
    logic txOverflow;
    logic rxRetryLimit;
    logic txRetryLimit;
  } scil_err_t;

  // one register write as seen by the register file
  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } scil_wr_t;

  typedef enum logic [1:0] {
    WR_COLLECT,
    WR_RESPOND
  } scil_wr_state_t;

endpackage : scil_pkg

// File: src/scil_axil_slave.sv
`timescale 1ns/100ps
`include "scil_defs.svh"

module scil_axil_slave #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              clkEn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output scil_pkg::scil_wr_t     wrReq,
  input  wire logic              wrErr,
  input  wire logic [31:0]       rdData,
  input  wire logic              rdErr
);

  scil_pkg::scil_wr_state_t state_r;
  logic                     awHeld_r;
  logic                     wHeld_r;
  logic [ADDR_W-1:0]        awAddr_r;
  logic [31:0]              wData_r;
  logic [3:0]               wStrb_r;
  logic                     awTake;
  logic                     wTake;
  logic                     haveAw;
  logic                     haveW;
  logic                     doWrite;
  logic                     arTake;

  // --------------------------------------------------------------
  // write channel: address and data taken in either order
  // --------------------------------------------------------------
  assign s_axi_awready = clkEn & (state_r == scil_pkg::WR_COLLECT) & ~awHeld_r;
  assign s_axi_wready  = clkEn & (state_r == scil_pkg::WR_COLLECT) & ~wHeld_r;
  assign s_axi_bvalid  = (state_r == scil_pkg::WR_RESPOND);
  assign awTake        = s_axi_awvalid & s_axi_awready;
  assign wTake         = s_axi_wvalid & s_axi_wready;
  assign haveAw        = awHeld_r | awTake;
  assign haveW         = wHeld_r | wTake;
  assign doWrite       = clkEn & (state_r == scil_pkg::WR_COLLECT) & haveAw & haveW;
  assign wrReq.en      = doWrite;
  assign wrReq.addr    = 8'(awHeld_r ? awAddr_r : s_axi_awaddr);
  assign wrReq.data    = wHeld_r ? wData_r : s_axi_wdata;
  assign wrReq.strb    = wHeld_r ? wStrb_r : s_axi_wstrb;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r     <= scil_pkg::WR_COLLECT;
      awHeld_r    <= 1'b0;
      wHeld_r     <= 1'b0;
      awAddr_r    <= '0;
      wData_r     <= '0;
      wStrb_r     <= '0;
      s_axi_bresp <= `SCIL_RESP_OKAY;
    end else if (clkEn) begin
      case (state_r)
        scil_pkg::WR_COLLECT: begin
          if (doWrite) begin
            state_r     <= scil_pkg::WR_RESPOND;
            awHeld_r    <= 1'b0;
            wHeld_r     <= 1'b0;
            s_axi_bresp <= wrErr ? `SCIL_RESP_SLVERR : `SCIL_RESP_OKAY;
          end else begin
            if (awTake) begin
              awHeld_r <= 1'b1;
              awAddr_r <= s_axi_awaddr;
            end
            if (wTake) begin
              wHeld_r <= 1'b1;
              wData_r <= s_axi_wdata;
              wStrb_r <= s_axi_wstrb;
            end
          end
        end
        scil_pkg::WR_RESPOND: begin
          if (s_axi_bready) begin
            state_r <= scil_pkg::WR_COLLECT;
          end
        end
        default: state_r <= scil_pkg::WR_COLLECT;
      endcase
    end
  end

  // --------------------------------------------------------------
  // read channel: one read at a time, data one cycle after address
  // --------------------------------------------------------------
  assign s_axi_arready = clkEn & ~s_axi_rvalid;
  assign arTake        = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `SCIL_RESP_OKAY;
    end else if (clkEn) begin
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdData;
        s_axi_rresp  <= rdErr ? `SCIL_RESP_SLVERR : `SCIL_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : scil_axil_slave

// File: src/scil_rx_timeout.sv
`timescale 1ns/100ps
`include "scil_defs.svh"

module scil_rx_timeout #(
  parameter int CNT_W = 9
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire logic             rxByteIn,
  input  wire logic             rxBufRead,
  input  wire logic             etuTick,
  input  wire logic [CNT_W-1:0] timeoutValue,
  output logic                  timeoutPulse
);

  logic [CNT_W-1:0] cnt_r;
  logic             armed_r;
  logic             restart;
  logic             fire;

  assign restart = rxByteIn | (rxBufRead & armed_r);
  assign fire    = armed_r & etuTick & (cnt_r <= CNT_W'(`SCIL_TO_FIRE));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r        <= '0;
      armed_r      <= 1'b0;
      timeoutPulse <= 1'b0;
    end else if (clkEn) begin
      timeoutPulse <= fire & ~restart;
      if (restart) begin
        cnt_r   <= timeoutValue;
        armed_r <= (timeoutValue != '0);
      end else if (fire) begin
        armed_r <= 1'b0;
      end else if (armed_r & etuTick) begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
    end
  end

  property p_to_restart;
    @(posedge mclk) disable iff (rst)
      (clkEn && rxByteIn) |=> (cnt_r == $past(timeoutValue)) && !timeoutPulse;
  endproperty
  a_to_restart: assert property (p_to_restart) else $error("time-out counter did not reload");

endmodule : scil_rx_timeout

// File: bench/scil_card_model.sv
`timescale 1ns/100ps

module scil_card_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [2:0] seqStart,
  input  wire logic       push,
  input  wire logic       pop,
  output logic      [2:0] seqDone,
  output logic            rxByteIn,
  output logic            rxBufRead,
  output logic      [2:0] rxCount,
  output logic            etuTick
);
  // ------
  // card side: sequencer, rx buffer, etu
  // ------
  logic [3:0] seqCnt_r;
  logic [1:0] etuCnt_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seqCnt_r  <= 4'h0;
      etuCnt_r  <= 2'h0;
      seqDone   <= 3'h0;
      rxByteIn  <= 1'b0;
      rxBufRead <= 1'b0;
      rxCount   <= 3'h0;
      etuTick   <= 1'b0;
    end else begin
      etuCnt_r  <= etuCnt_r + 2'h1;
      etuTick   <= (etuCnt_r == 2'h3);
      rxByteIn  <= push;
      rxBufRead <= pop;
      rxCount   <= rxCount + {2'h0, push} - {2'h0, pop};
      seqCnt_r  <= (seqStart != 3'h0 && seqDone == 3'h0) ? seqCnt_r + 4'h1 : 4'h0;
      seqDone   <= (seqCnt_r == 4'h6) ? seqStart : 3'h0;
    end
  end
endmodule : scil_card_model

// File: bench/smart_card_interrupt_logic_tb.sv
`timescale 1ns/100ps
`include "scil_defs.svh"

module smart_card_interrupt_logic_tb;
  logic        mclk, rst, clkEn, convCharValid, cardInserted, cardRemoved, guardTimeEvent, txEmpty, txHoldWrite;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, push, pop;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rxByteIn, rxBufRead, etuTick, rxGuardOn, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rxTriggerLevel, rsp;
  logic [2:0]  timerEvent, rxCount, seqDone, seqStart;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, convChar;
  logic [8:0]  rxTimeoutValue;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  scil_pkg::scil_err_t errFlags;
  int          err_total, cmp_count, i, n;
  int          bits[6] = '{3, 4, 5, 6, 7, 10};

  scil_irq_top #(.ADDR_W(8), .TO_W(9)) scil_irq_top_inst (
    .mclk, .rst, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .convCharValid, .convChar, .cardInserted, .cardRemoved, .guardTimeEvent, .timerEvent, .errFlags,
    .txEmpty, .txHoldWrite, .rxByteIn, .rxBufRead, .rxCount, .rxTriggerLevel, .rxTimeoutValue,
    .etuTick, .seqDone, .seqStart, .rxGuardOn, .irq);
  scil_card_model scil_card_model_inst (
    .mclk, .rst, .seqStart, .push, .pop, .seqDone, .rxByteIn, .rxBufRead, .rxCount, .etuTick);

  // ------
  // bus and event tasks
  // ------
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    int   k;
    aw = 1'b1;
    w = 1'b1;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge mclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (k == 64) begin
      err_total++;
      $display("Error at %0t: write timed out", $time);
    end
  endtask : wr

  task rd(input logic [7:0] a);
    int k;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (k == 64) begin
      err_total++;
      $display("Error at %0t: read timed out", $time);
    end
  endtask : rd

  task st(input logic [31:0] e);
    rd(`SCIL_OFS_STATUS);
    chk(d, e);
  endtask : st

  // one-cycle pulse of the event input selected by code
  task fire(input int b);
    @(posedge mclk);
    case (b)
      1:  txHoldWrite <= 1'b1;
      6:  guardTimeEvent <= 1'b1;
      7:  cardInserted <= 1'b1;
      10: convCharValid <= 1'b1;
      11: push <= 1'b1;
      12: pop <= 1'b1;
      13: cardRemoved <= 1'b1;
      default: timerEvent <= 3'(1 << (b - 3));
    endcase
    @(posedge mclk);
    {txHoldWrite, guardTimeEvent, cardInserted, cardRemoved, convCharValid, push, pop} <= 7'h00;
    timerEvent <= 3'h0;
  endtask : fire

  task end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // ------
  // stimulus
  // ------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    #2_000_000;
    err_total++;
    end_of_test();
  end

  initial begin
    {convCharValid, cardInserted, cardRemoved, guardTimeEvent, txHoldWrite, push, pop} = 7'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {timerEvent, errFlags, rxTimeoutValue} = 19'h0;
    rst = 1'b1;
    clkEn = 1'b1;
    txEmpty = 1'b1;
    s_axi_wstrb = 4'hF;
    convChar = `SCIL_TS_DIRECT;
    rxTriggerLevel = 2'h1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(`SCIL_OFS_ENABLE);
    chk(d, 32'h0);
    st(32'h2);
    rd(8'h30);
    chk({30'h0, rsp}, {30'h0, `SCIL_RESP_SLVERR});
    chk(d, 32'h0);
    fire(3);
    wr(`SCIL_OFS_ENABLE, 32'hFFFF_FFFF);
    rd(`SCIL_OFS_ENABLE);
    chk(d, 32'h7FF);
    chk({31'h0, irq}, 32'h1);
    wr(`SCIL_OFS_STATUS, 32'h8);
    st(32'h2);
    txEmpty <= 1'b0;
    fire(1);
    st(32'h0);
    chk({31'h0, irq}, 32'h0);
    txEmpty <= 1'b1;
    wr(`SCIL_OFS_STATUS, 32'h2);
    st(32'h2);
    fire(1);
    fire(10);
    convChar <= `SCIL_TS_INVERSE;
    fire(10);
    st(32'h0);
    convChar <= 8'h5A;
    fire(6);
    st(32'h0);
    wr(8'h40, 32'h8);
    chk({31'h0, rxGuardOn}, 32'h1);
    foreach (bits[j]) begin
      fire(bits[j]);
      st(32'h1 << bits[j]);
      chk({31'h0, irq}, 32'h1);
      wr(`SCIL_OFS_STATUS, 32'h0);
      st(32'h1 << bits[j]);
      wr(`SCIL_OFS_STATUS, 32'h1 << bits[j]);
      st(32'h0);
    end
    fire(13);
    st(32'h80);
    wr(`SCIL_OFS_STATUS, 32'h80);
    st(32'h0);
    wr(`SCIL_OFS_ENABLE, 32'h3FF);
    fire(10);
    st(32'h400);
    chk({31'h0, irq}, 32'h0);
    wr(`SCIL_OFS_STATUS, 32'h400);
    for (i = 0; i < 3; i++) begin
      wr(8'h40, 32'h8 | (32'h1 << i));
      chk({29'h0, seqStart}, 32'h1 << i);
      for (n = 0; n < 50 && seqStart !== 3'h0; n++) @(posedge mclk);
      st(32'h100);
      wr(`SCIL_OFS_STATUS, 32'h100);
      st(32'h0);
    end
    for (i = 0; i < 7; i++) begin
      errFlags <= scil_pkg::scil_err_t'(7'h1 << i);
      st(32'h4);
      wr(`SCIL_OFS_STATUS, 32'h4);
      st(32'h4);
      errFlags <= scil_pkg::scil_err_t'(7'h0);
      st(32'h0);
    end
    fire(11);
    st(32'h0);
    fire(11);
    st(32'h1);
    fire(12);
    st(32'h0);
    fire(12);
    rxTimeoutValue <= 9'h003;
    fire(11);
    st(32'h0);
    repeat (20) @(posedge mclk);
    st(32'h200);
    wr(`SCIL_OFS_STATUS, 32'h200);
    st(32'h200);
    rxTimeoutValue <= 9'h000;
    fire(12);
    st(32'h0);
    clkEn <= 1'b0;
    fire(3);
    clkEn <= 1'b1;
    st(32'h0);
    end_of_test();
  end
endmodule : smart_card_interrupt_logic_tb
